// ---- core/prompt_record_card_logic.sv ----
`timescale 1ns/10ps
`default_nettype none
module prompt_record_card_logic
  import prompt_record_pkg::*;
#(
  parameter int BLINK_CYC     = BLINK_HALF_CYC,
  parameter int HEARTBEAT_CYC = HEARTBEAT_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Configuration
  input  wire logic [1:0]  capSel,
  input  wire logic [7:0]  cardAddr,
  // Processor access to buffers and slot map
  input  wire logic        pbWrEn,
  input  wire logic [11:0] pbWrAddr,
  input  wire logic [7:0]  pbWrData,
  input  wire logic        mapWrEn,
  input  wire logic        mapIsRecord,
  input  wire logic        mapAssign,
  input  wire logic [7:0]  mapSlot,
  input  wire logic [6:0]  mapChan,
  input  wire logic [9:0]  recRdAddr,
  output logic      [7:0]  recRdData,
  // PCM bus
  input  wire logic        pcmFrameSync,
  input  wire logic        pcmSlotStrobe,
  input  wire logic [7:0]  pcmSlot,
  input  wire logic [7:0]  pcmRxData,
  output logic      [7:0]  pcmTxData,
  output logic             pcmTxEn,
  // Port block
  output logic      [7:0]  blockFirst,
  output logic      [7:0]  blockSize,
  // Comm bus status
  input  wire logic        pollReq,
  input  wire logic        statusChanged,
  output logic             statusReply,
  output logic             replyValid,
  // DMA
  input  wire logic        dmaActive,
  output logic             dataBusLock,
  // Lamps
  input  wire logic [3:0]  cardState,
  input  wire logic        bgRunning,
  input  wire logic        cpuHalt,
  output logic             majorFaultLamp,
  output logic             minorFaultLamp,
  output logic             standbyLamp,
  output logic             heartbeatLamp,
  output logic             haltLamp
);

  //============================================================================
  // State
  typedef struct packed {
    logic [7:0]   addrS1;
    logic [7:0]   addrS2;
    logic         frmS1;
    logic         frmS2;
    logic         frmPrev;
    logic         stbS1;
    logic         stbS2;
    logic         stbPrev;
    logic [7:0]   slotS1;
    logic [7:0]   slotS2;
    logic [7:0]   rxS1;
    logic [7:0]   rxS2;
    logic         pollS1;
    logic         pollS2;
    logic         pollPrev;
    logic         haltS1;
    logic         haltS2;
    logic [4:0]   frameIdx;
    logic [255:0] pbSlotOn;
    logic [255:0] recSlotOn;
    logic [23:0]  blinkCnt;
    logic         blinkPhase;
    logic [23:0]  hbCnt;
    logic         hbLamp;
    logic         green;
    logic         yellow;
    logic         red;
    logic         halt;
    logic [7:0]   txData;
    logic         txEn;
    logic [7:0]   recRd;
    logic [7:0]   blkFirst;
    logic [7:0]   blkSize;
    logic         pending;
    logic         reply;
    logic         replyV;
    logic         busLock;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // Buffers are plain RAM; only the slot-valid bits need a reset value
  logic [7:0] pbBuf  [PB_BUF_BYTES];
  logic [7:0] recBuf [REC_BUF_BYTES];
  logic [6:0] pbSlotChan  [PCM_SLOTS];
  logic [4:0] recSlotChan [PCM_SLOTS];

  logic       slotEdge;
  logic       frameEdge;
  logic       pollEdge;
  logic [7:0] pbLimit;
  logic [7:0] recLimit;
  logic [6:0] curPb;
  logic [4:0] curRec;
  logic       recHit;

  assign slotEdge  = st_ff.stbS2 & ~st_ff.stbPrev;
  assign frameEdge = st_ff.frmS2 & ~st_ff.frmPrev;
  assign pollEdge  = st_ff.pollS2 & ~st_ff.pollPrev;
  assign curPb     = pbSlotChan[st_ff.slotS2];
  assign curRec    = recSlotChan[st_ff.slotS2];
  assign recHit    = slotEdge & st_ff.recSlotOn[st_ff.slotS2]
                     & ({3'b000, curRec} < recLimit);

  //============================================================================
  // Capacity decode
  always_comb begin
    case (capacity_t'(capSel))
      CAP_8_4: begin
        pbLimit  = PB_PORTS_SMALL;                                        // [RULE_05]
        recLimit = REC_PORTS_SMALL;
      end
      CAP_64_32: begin
        pbLimit  = PB_PORTS_MID;
        recLimit = REC_PORTS_BIG;
      end
      CAP_128_32: begin
        pbLimit  = PB_PORTS_LARGE;
        recLimit = REC_PORTS_BIG;
      end
      default: begin
        pbLimit  = PB_PORTS_SMALL;
        recLimit = REC_PORTS_SMALL;
      end
    endcase
  end

  //============================================================================
  // Buffer memories
  always_ff @(posedge clock) begin
    if (pbWrEn) begin
      pbBuf[pbWrAddr] <= pbWrData;                                        // [RULE_01]
    end
    if (recHit) begin
      recBuf[{curRec, st_ff.frameIdx}] <= st_ff.rxS2;                     // [RULE_02]
    end
    if (mapWrEn && mapAssign && !mapIsRecord) begin
      pbSlotChan[mapSlot] <= mapChan;
    end
    if (mapWrEn && mapAssign && mapIsRecord) begin
      recSlotChan[mapSlot] <= mapChan[4:0];
    end
  end

  //============================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;

    // Two flip-flops on the card address, PCM bus, poll and halt inputs
    nxt_st.addrS1 = cardAddr;
    nxt_st.addrS2 = st_ff.addrS1;
    nxt_st.frmS1  = pcmFrameSync;
    nxt_st.frmS2  = st_ff.frmS1;
    nxt_st.frmPrev = st_ff.frmS2;
    nxt_st.stbS1  = pcmSlotStrobe;
    nxt_st.stbS2  = st_ff.stbS1;
    nxt_st.stbPrev = st_ff.stbS2;
    nxt_st.slotS1 = pcmSlot;
    nxt_st.slotS2 = st_ff.slotS1;
    nxt_st.rxS1   = pcmRxData;
    nxt_st.rxS2   = st_ff.rxS1;
    nxt_st.pollS1 = pollReq;
    nxt_st.pollS2 = st_ff.pollS1;
    nxt_st.pollPrev = st_ff.pollS2;
    nxt_st.haltS1 = cpuHalt;
    nxt_st.haltS2 = st_ff.haltS1;

    // Each frame carries one byte per channel; the index walks the 32-byte ring
    if (frameEdge) begin
      nxt_st.frameIdx = st_ff.frameIdx + 5'd1;                            // [RULE_07]
    end

    if (mapWrEn && !mapIsRecord) begin
      nxt_st.pbSlotOn[mapSlot] = mapAssign;
    end
    if (mapWrEn && mapIsRecord) begin
      nxt_st.recSlotOn[mapSlot] = mapAssign;
    end

    // Drive stays on for the whole slot and drops at the next slot boundary
    if (slotEdge) begin
      if (st_ff.pbSlotOn[st_ff.slotS2] && ({1'b0, curPb} < pbLimit)) begin
        nxt_st.txEn   = 1'b1;                                             // [RULE_04]
        nxt_st.txData = pbBuf[{curPb, st_ff.frameIdx}];
      end else begin
        nxt_st.txEn   = 1'b0;
        nxt_st.txData = RST_BYTE;
      end
    end

    nxt_st.recRd = recBuf[recRdAddr];

    nxt_st.blkFirst = st_ff.addrS2;                                       // [RULE_03]
    nxt_st.blkSize  = pbLimit;

    // A change arriving with the poll stays pending for the next one
    nxt_st.replyV = 1'b0;
    if (pollEdge) begin
      nxt_st.replyV  = 1'b1;                                              // [RULE_14]
      nxt_st.reply   = st_ff.pending;
      nxt_st.pending = statusChanged;
    end else if (statusChanged) begin
      nxt_st.pending = 1'b1;
    end

    nxt_st.busLock = dmaActive;                                           // [RULE_13]
    nxt_st.halt    = st_ff.haltS2;                                        // [RULE_11]

    if (st_ff.blinkCnt == 24'(BLINK_CYC - 1)) begin
      nxt_st.blinkCnt   = RST_COUNT;                                      // [RULE_16]
      nxt_st.blinkPhase = ~st_ff.blinkPhase;
    end else begin
      nxt_st.blinkCnt = st_ff.blinkCnt + 24'd1;
    end

    // Counter freezes with the lamp so the lamp holds its last level
    if (bgRunning) begin
      if (st_ff.hbCnt == 24'(HEARTBEAT_CYC - 1)) begin
        nxt_st.hbCnt  = RST_COUNT;                                        // [RULE_12]
        nxt_st.hbLamp = ~st_ff.hbLamp;
      end else begin
        nxt_st.hbCnt = st_ff.hbCnt + 24'd1;
      end
    end

    case (card_state_t'(cardState))
      ST_PLUGGED:   {nxt_st.green, nxt_st.yellow, nxt_st.red} = 3'b111;   // [RULE_08]
      ST_SELF_TEST: {nxt_st.green, nxt_st.yellow, nxt_st.red} =
                    {1'b1, st_ff.blinkPhase, 1'b0};                       // [RULE_08]
      ST_DOWNLOAD:  {nxt_st.green, nxt_st.yellow, nxt_st.red} =
                    {st_ff.blinkPhase, 2'b00};                            // [RULE_08]
      ST_OUT_OF_SV: {nxt_st.green, nxt_st.yellow, nxt_st.red} = 3'b100;   // [RULE_09]
      ST_STANDBY:   {nxt_st.green, nxt_st.yellow, nxt_st.red} = 3'b110;   // [RULE_09]
      ST_FAILED:    {nxt_st.green, nxt_st.yellow, nxt_st.red} = 3'b101;   // [RULE_09]
      ST_MAJOR:     {nxt_st.green, nxt_st.yellow, nxt_st.red} = 3'b001;   // [RULE_10]
      ST_MINOR:     {nxt_st.green, nxt_st.yellow, nxt_st.red} = 3'b010;   // [RULE_10]
      default:      {nxt_st.green, nxt_st.yellow, nxt_st.red} = 3'b000;
    endcase
  end

  //============================================================================
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.green  <= 1'b1;
      st_ff.yellow <= 1'b1;
      st_ff.red    <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign recRdData      = st_ff.recRd;
  assign pcmTxData      = st_ff.txData;
  assign pcmTxEn        = st_ff.txEn;
  assign blockFirst     = st_ff.blkFirst;
  assign blockSize      = st_ff.blkSize;
  assign statusReply    = st_ff.reply;
  assign replyValid     = st_ff.replyV;
  assign dataBusLock    = st_ff.busLock;
  assign majorFaultLamp = st_ff.red;
  assign minorFaultLamp = st_ff.yellow;
  assign standbyLamp    = st_ff.green;
  assign heartbeatLamp  = st_ff.hbLamp;
  assign haltLamp       = st_ff.halt;

endmodule : prompt_record_card_logic
`default_nettype wire

// ---- core/prompt_record_pkg.sv ----
//==============================================================================
// Notes on behaviour
// RULE_01: Playback PCM buffered for 128 channels, 32 bytes each, 4 KB in total.
// RULE_02: Record PCM buffered for up to 32 channels, apart from playback buffers.
// RULE_03: Card claims consecutive port addresses, block sized by configuration, at most 128.
// RULE_04: Playback data is driven onto the bus only in its assigned time slot.
// RULE_05: Capacities are 8/4, 64/32 or 128/32 playback/record ports.
// RULE_06: At most 16 libraries of 256 prompts, 35 minutes combined.
// RULE_07: Samples are 64 kbit/s PCM, one byte per channel per frame.
// RULE_08: Startup lamps: all on; then self test; then download with green blinking.
// RULE_09: Out of service green; standby green and yellow; failure green and red.
// RULE_10: Major alarm lights red only, minor alarm lights yellow only.
// RULE_11: Halt lamp follows the processor halt line.
// RULE_12: Heartbeat lamp toggles while background runs, holds when interrupted.
// RULE_13: DMA moves 16-bit words; the shared bus is locked to others meanwhile.
// RULE_14: Commands arrive as packets; a poll is answered with pending status changes.
// RULE_15: Prompt memory is 16 MB from thirty-two 1M x 4 DRAM devices.
// RULE_16: Blink and heartbeat periods are parameters derived from the card clock.
package prompt_record_pkg;

  //============================================================================
  // Buffers and capacity
  localparam int PB_CHANS          = 128;
  localparam int PB_BYTES_PER_CHAN = 32;
  localparam int PB_BUF_BYTES      = 4096;   // [RULE_01]
  localparam int REC_CHANS         = 32;     // [RULE_02]
  localparam int REC_BUF_BYTES     = REC_CHANS * PB_BYTES_PER_CHAN;
  localparam int MAX_PORT_BLOCK    = 128;    // [RULE_03]
  localparam int PCM_SLOTS         = 256;
  localparam int SAMPLE_BITS       = 8;      // [RULE_07]
  localparam int PCM_KBPS          = 64;

  // Capacity sizes per configuration
  localparam logic [7:0] PB_PORTS_SMALL  = 8'h08;
  localparam logic [7:0] PB_PORTS_MID    = 8'h40;
  localparam logic [7:0] PB_PORTS_LARGE  = 8'h80;
  localparam logic [7:0] REC_PORTS_SMALL = 8'h04;
  localparam logic [7:0] REC_PORTS_BIG   = 8'h20;

  // Prompt store limits
  localparam int PROMPT_LIBRARIES  = 16;     // [RULE_06]
  localparam int PROMPTS_PER_LIB   = 256;
  localparam int MAX_PROMPT_MIN    = 35;
  localparam int DRAM_MBYTES       = 16;     // [RULE_15]
  localparam int DRAM_DEVICES      = 32;
  localparam int DRAM_DEV_DEPTH    = 1048576;
  localparam int DRAM_DEV_BITS     = 4;
  localparam int DMA_WORD_BITS     = 16;     // [RULE_13]

  //============================================================================
  // Timing
  localparam int CLOCK_HZ          = 20000000;
  localparam int BLINK_HALF_MS     = 500;
  localparam int HEARTBEAT_HALF_MS = 500;
  localparam int BLINK_HALF_CYC    = (CLOCK_HZ / 1000) * BLINK_HALF_MS;     // [RULE_16]
  localparam int HEARTBEAT_HALF_CYC = (CLOCK_HZ / 1000) * HEARTBEAT_HALF_MS;

  //============================================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_FRAME = 5'h00;
  localparam logic [23:0] RST_COUNT = 24'h00_0000;

  typedef enum logic [1:0] {
    CAP_8_4    = 2'b00,
    CAP_64_32  = 2'b01,
    CAP_128_32 = 2'b10
  } capacity_t;

  typedef enum logic [3:0] {
    ST_PLUGGED   = 4'b0000,
    ST_SELF_TEST = 4'b0001,
    ST_DOWNLOAD  = 4'b0010,
    ST_OUT_OF_SV = 4'b0011,
    ST_STANDBY   = 4'b0100,
    ST_MAJOR     = 4'b0101,
    ST_MINOR     = 4'b0110,
    ST_FAILED    = 4'b0111,
    ST_ACTIVE    = 4'b1000
  } card_state_t;

endpackage : prompt_record_pkg

// ---- tb/prompt_record_card_logic_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
//==============================================================
// Port-level checks, all on the card clock
module prompt_record_card_logic_chk
  import prompt_record_pkg::*;
#(parameter int HEARTBEAT_CYC = 8, parameter int BLINK_CYC = 8) (
  // Clock, reset, configuration
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [1:0] capSel,
  input wire logic [7:0] blockSize,
  // Buses
  input wire logic       pcmSlotStrobe,
  input wire logic [7:0] pcmTxData,
  input wire logic       pcmTxEn,
  input wire logic       pollReq,
  input wire logic       replyValid,
  input wire logic       dmaActive,
  input wire logic       dataBusLock,
  // Lamps
  input wire logic [3:0] cardState,
  input wire logic       bgRunning,
  input wire logic       cpuHalt,
  input wire logic       majorFaultLamp,
  input wire logic       minorFaultLamp,
  input wire logic       standbyLamp,
  input wire logic       heartbeatLamp,
  input wire logic       haltLamp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [2:0] ryg;
  logic [7:0] quiet_ff;
  logic [7:0] still_ff;
  logic       hbPrev_ff;
  logic       blinkPrev_ff;
  logic       blinking;
  logic       blinkLamp;
  assign ryg       = {majorFaultLamp, minorFaultLamp, standbyLamp};
  assign blinking  = cardState == 4'h1 || cardState == 4'h2;
  assign blinkLamp = cardState == 4'h1 ? minorFaultLamp : standbyLamp;
  // Cycles without a lamp change while it should be moving; a plain copy of
  // the last level keeps the clock of the compare unambiguous under async reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      quiet_ff     <= 8'h00;
      still_ff     <= 8'h00;
      hbPrev_ff    <= 1'b0;
      blinkPrev_ff <= 1'b0;
    end else begin
      hbPrev_ff    <= heartbeatLamp;
      blinkPrev_ff <= blinkLamp;
      if (!bgRunning || heartbeatLamp != hbPrev_ff) quiet_ff <= 8'h00;
      else quiet_ff <= quiet_ff + 8'h01;
      if (!blinking || blinkLamp != blinkPrev_ff) still_ff <= 8'h00;
      else still_ff <= still_ff + 8'h01;
    end
  end
  // State must be seen twice: it is decoded one cycle before the lamps
  sequence held(logic [3:0] s);
    cardState == s [*2];
  endsequence
  chk_plug_lamps: assert property (held(4'h0) |=> ryg == 3'b111) else $error("plug lamps");
  chk_oos_lamps: assert property (held(4'h3) |=> ryg == 3'b001) else $error("oos lamps");
  chk_standby_lamps: assert property (held(4'h4) |=> ryg == 3'b011) else $error("sby lamps");
  chk_failed_lamps: assert property (held(4'h7) |=> ryg == 3'b101) else $error("fail lamps");
  chk_major_lamps: assert property (held(4'h5) |=> ryg == 3'b100) else $error("major lamps");
  chk_minor_lamps: assert property (held(4'h6) |=> ryg == 3'b010) else $error("minor lamps");
  chk_halt_on: assert property (cpuHalt [*4] |=> haltLamp) else $error("halt lamp off");
  chk_halt_off: assert property (!cpuHalt [*4] |=> !haltLamp) else $error("halt lamp on");
  chk_hb_hold: assert property (!bgRunning |=> $stable(heartbeatLamp)) else $error("hb moved");
  chk_hb_toggle: assert property (quiet_ff <= HEARTBEAT_CYC + 1) else $error("hb stuck");
  chk_blink_moves: assert property (still_ff <= BLINK_CYC + 2) else $error("no blink");
  chk_bus_lock: assert property (dmaActive |=> dataBusLock) else $error("bus not locked");
  chk_reply_pulse: assert property (replyValid |=> !replyValid) else $error("reply long");
  chk_reply_time: assert property ($rose(pollReq) |-> ##[3:5] replyValid) else $error("no reply");
  chk_tx_hold: assert property (!pcmSlotStrobe [*6] |=> $stable({pcmTxEn, pcmTxData}))
    else $error("tx moved between slots");
  chk_block_size: assert property ($stable(capSel) |=> blockSize == ($past(capSel) == 2'b01 ?
    PB_PORTS_MID : $past(capSel) == 2'b10 ? PB_PORTS_LARGE : PB_PORTS_SMALL)) else $error("size");
endmodule : prompt_record_card_logic_chk
bind prompt_record_card_logic prompt_record_card_logic_chk
  #(.HEARTBEAT_CYC(HEARTBEAT_CYC), .BLINK_CYC(BLINK_CYC)) chk (
  .clock, .rst, .capSel, .blockSize, .pcmSlotStrobe, .pcmTxData, .pcmTxEn, .pollReq,
  .replyValid, .dmaActive, .dataBusLock, .cardState, .bgRunning, .cpuHalt, .majorFaultLamp,
  .minorFaultLamp, .standbyLamp, .heartbeatLamp, .haltLamp);
`default_nettype wire

// ---- tb/pcm_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
//==============================================================
// Bus controller side: drives slots and polls, pins change at falling edge
module pcm_host_model (
  input wire logic        clock,
  input wire logic        replyValid,
  input wire logic        statusReply,
  output var logic        pcmFrameSync,
  output var logic        pcmSlotStrobe,
  output var logic        pollReq,
  output var logic  [7:0] pcmSlot,
  output var logic  [7:0] pcmRxData
);
  initial {pcmFrameSync, pcmSlotStrobe, pollReq, pcmSlot, pcmRxData} = 19'h0_0000;
  task automatic sendSlot(input logic [7:0] s, input logic [7:0] d);
    @(negedge clock);
    pcmSlot = s;
    pcmRxData = d;
    @(negedge clock);
    pcmSlotStrobe = 1'b1;
    repeat (4) @(negedge clock);
    pcmSlotStrobe = 1'b0;
    // Hold time over: show the inverse so stale data cannot pass
    pcmSlot = ~s;
    pcmRxData = ~d;
    repeat (2) @(negedge clock);
  endtask : sendSlot
  // One frame boundary: the card moves to the next byte of every ring
  task automatic frame;
    @(negedge clock);
    pcmFrameSync = 1'b1;
    repeat (2) @(negedge clock);
    pcmFrameSync = 1'b0;
    repeat (2) @(negedge clock);
  endtask : frame
  task automatic poll(output logic st, output logic ok);
    @(negedge clock);
    pollReq = 1'b1;
    ok = 1'b0;
    st = 1'b0;
    repeat (8) begin
      @(negedge clock);
      if (replyValid === 1'b1 && !ok) begin
        ok = 1'b1;
        st = statusReply;
      end
    end
    pollReq = 1'b0;
    repeat (4) @(negedge clock);
  endtask : poll
endmodule : pcm_host_model
`default_nettype wire

// ---- tb/test_prompt_record_card_logic.sv ----
`timescale 1ns/10ps
`default_nettype none
//==============================================================
// Self-checking bench
module test_prompt_record_card_logic;
  import prompt_record_pkg::*;
  logic clock = 1'b0, rst = 1'b1, pbWrEn = 1'b0, mapWrEn = 1'b0, mapIsRecord = 1'b0;
  logic mapAssign = 1'b0, statusChanged = 1'b0, dmaActive = 1'b0, bgRunning = 1'b0;
  logic cpuHalt = 1'b0, pcmFrameSync, pcmSlotStrobe, pollReq, pcmTxEn, statusReply, replyValid;
  logic dataBusLock, majorFaultLamp, minorFaultLamp, standbyLamp, heartbeatLamp, haltLamp;
  logic [1:0] capSel = 2'b00;
  logic [3:0] cardState = 4'h0;
  logic [6:0] mapChan = 7'h00, chan;
  logic [7:0] cardAddr = 8'h00, pbWrData = 8'h00, mapSlot = 8'h00, pcmSlot, pcmRxData;
  logic [7:0] recRdData, pcmTxData, blockFirst, blockSize, data, slot;
  logic [9:0] recRdAddr = 10'h000;
  logic [11:0] pbWrAddr = 12'h000;
  logic [5:0] exp;
  logic st, ok, chg;
  int err_count = 0, n_compared = 0, cycles = 0, frames = 0;
  always #25 clock = ~clock;
  prompt_record_card_logic #(.BLINK_CYC(8), .HEARTBEAT_CYC(8)) dut (.clock, .rst, .capSel,
    .cardAddr, .pbWrEn, .pbWrAddr, .pbWrData, .mapWrEn, .mapIsRecord, .mapAssign, .mapSlot,
    .mapChan, .recRdAddr, .recRdData, .pcmFrameSync, .pcmSlotStrobe, .pcmSlot, .pcmRxData,
    .pcmTxData, .pcmTxEn, .blockFirst, .blockSize, .pollReq, .statusChanged, .statusReply,
    .replyValid, .dmaActive, .dataBusLock, .cardState, .bgRunning, .cpuHalt, .majorFaultLamp,
    .minorFaultLamp, .standbyLamp, .heartbeatLamp, .haltLamp);
  pcm_host_model host (.clock, .replyValid, .statusReply, .pcmFrameSync, .pcmSlotStrobe,
    .pollReq, .pcmSlot, .pcmRxData);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic test_done;
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // Mask of defined lamps and their levels, {red, yellow, green}; blinking ones masked
  function automatic logic [5:0] lampExp(input logic [3:0] s);
    case (s)
      4'h0: return 6'b111_111;
      4'h1: return 6'b101_001;
      4'h2: return 6'b110_000;
      4'h3: return 6'b111_001;
      4'h4: return 6'b111_011;
      4'h5: return 6'b111_100;
      4'h6: return 6'b111_010;
      4'h7: return 6'b111_101;
      default: return 6'b111_000;
    endcase
  endfunction : lampExp
  // Byte that fillChan leaves at the ring position of a given frame count
  function automatic logic [7:0] ringByte(input logic [7:0] d, input int f);
    return d ^ 8'(f % PB_BYTES_PER_CHAN);
  endfunction : ringByte
  task automatic fillChan(input logic [6:0] ch, input logic [7:0] d);
    for (int f = 0; f < PB_BYTES_PER_CHAN; f++) begin
      @(negedge clock);
      {pbWrEn, pbWrAddr, pbWrData} = {1'b1, ch, 5'(f), d ^ 8'(f)};
    end
    @(negedge clock);
    pbWrEn = 1'b0;
  endtask : fillChan
  task automatic mapWrite(input logic [7:0] s, input logic [6:0] ch, input logic a);
    @(negedge clock);
    {mapWrEn, mapAssign, mapSlot, mapChan} = {1'b1, a, s, ch};
    @(negedge clock);
    mapWrEn = 1'b0;
  endtask : mapWrite
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h9ad48f2e));
    repeat (2) @(negedge clock);
    check({majorFaultLamp, minorFaultLamp, standbyLamp, heartbeatLamp, haltLamp}, 8'h1c);
    rst = 1'b0;
    for (int s = 0; s < 10; s++) begin
      cardState = 4'(s);
      repeat (s == 1 || s == 2 ? 20 : 3) @(negedge clock);
      exp = lampExp(cardState);
      check({majorFaultLamp, minorFaultLamp, standbyLamp} & exp[5:3], exp[2:0]);
    end
    for (int c = 0; c < 4; c++) begin
      capSel = 2'(c);
      cardAddr = 8'($urandom);
      repeat (4) @(negedge clock);
      check(blockFirst, cardAddr);
      check(blockSize, c == 1 ? PB_PORTS_MID : c == 2 ? PB_PORTS_LARGE : PB_PORTS_SMALL);
    end
    for (int i = 0; i < 12; i++) begin
      {cpuHalt, dmaActive, bgRunning, recRdAddr} = 13'($urandom);
      repeat (6 + $urandom % 20) @(negedge clock);
      check(haltLamp, cpuHalt);
      check(dataBusLock, dmaActive);
    end
    // Smallest capacity: channels 8 and up must stay silent
    for (int i = 0; i < 6; i++) begin
      host.frame();
      frames++;
      chan = i == 0 ? 7'h07 : i == 1 ? 7'h08 : 7'($urandom % 16);
      {slot, data} = 16'($urandom);
      fillChan(chan, data);
      mapWrite(slot, chan, 1'b1);
      host.sendSlot(slot, 8'($urandom));
      check(pcmTxEn, chan < 7'h08);
      if (chan < 7'h08) check(pcmTxData, ringByte(data, frames));
      mapWrite(slot, chan, 1'b0);
      host.sendSlot(slot, data);
      check(pcmTxEn, 1'b0);
    end
    // Record at 64/32 on channel 5; 34 frames take the ring past its wrap
    capSel = 2'b01;
    mapIsRecord = 1'b1;
    mapWrite(8'h10, 7'h05, 1'b1);
    mapWrite(8'h11, 7'h02, 1'b1);
    for (int i = 0; i < 34; i++) begin
      host.frame();
      frames++;
      data = 8'($urandom);
      host.sendSlot(8'h10, data);
      recRdAddr = {5'h05, 5'(frames)};
      @(negedge clock);
      check(recRdData, data);
    end
    // At 8/4 channel 5 is past the record limit and keeps its byte; channel 2 lands
    capSel = 2'b11;
    host.sendSlot(8'h10, ~data);
    host.sendSlot(8'h11, 8'h3c);
    recRdAddr = {5'h05, 5'(frames)};
    @(negedge clock);
    check(recRdData, data);
    recRdAddr = {5'h02, 5'(frames)};
    @(negedge clock);
    check(recRdData, 8'h3c);
    for (int i = 0; i < 6; i++) begin
      chg = i < 2 ? !i[0] : 1'($urandom);
      @(negedge clock);
      statusChanged = chg;
      @(negedge clock);
      statusChanged = 1'b0;
      host.poll(st, ok);
      check(ok, 1'b1);
      check(st, chg);
    end
    test_done();
  end
endmodule : test_prompt_record_card_logic
`default_nettype wire
